/* File: design/adc_sequencer_8bit.sv */
/*
  Sequencer for an 8-bit successive-approximation converter with an
  eight-way input mux, reached as an Avalon-MM slave with waitrequest.
  Assumes the analog front end delivers each input and both references
  as unsigned levels synchronous to clk_in, and that software keeps
  the reserved control bits at zero and sets the channel before power.
*/
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"

module adc_sequencer_8bit import adc_seq_pkg::*; #(
  parameter int LEVEL_W = 12,
  parameter int STAB_CYCLES =
    (`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic [7:0][LEVEL_W-1:0] analog_input_in,
  input wire logic [LEVEL_W-1:0] ref_high_in,
  input wire logic [LEVEL_W-1:0] ref_low_in,
  input wire logic deep_stop_in,
  output logic [2:0] mux_select_out,
  output logic converter_enable_out,
  output logic sampling_out,
  output logic irq_out
);

  // ==========================================================
  // Derived counts
  localparam int SAMPLE_CYCLES = (`SAMPLE_HALF_CYCLES + 1) / 2;
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYCLES - 1);
  localparam logic [5:0] CONV_LAST = 6'(`CONV_CYCLES - 1);
  localparam int STAB_W = $clog2(STAB_CYCLES + 1);
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);
  localparam int PROD_W = LEVEL_W + 8;

  // ==========================================================
  // Helpers
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  // Distance above the floor, clamped at zero
  function automatic logic [LEVEL_W-1:0] above(
    input logic [LEVEL_W-1:0] v,
    input logic [LEVEL_W-1:0] floor_v
  );
    return (v > floor_v) ? LEVEL_W'(v - floor_v) : '0;
  endfunction

  function automatic logic [PROD_W-1:0] mul(
    input logic [7:0] code,
    input logic [LEVEL_W-1:0] level
  );
    return PROD_W'(code) * PROD_W'(level);
  endfunction

  // ==========================================================
  // Declarations
  conv_state_t state_r;
  logic ack_r;
  logic req;
  logic accept;
  logic wr_ctrl;
  logic rd_result;
  logic wr_status;
  logic wr_mask;
  logic power_on_r;
  logic power_on_nxt;
  logic [2:0] channel_r;
  logic done_r;
  logic [7:0] result_r;
  logic [5:0] cnt_r;
  logic [STAB_W-1:0] stab_cnt_r;
  logic [LEVEL_W-1:0] hold_r;
  logic [LEVEL_W-1:0] span_r;
  logic [7:0] sar_r;
  logic [7:0] mask_r;
  logic [7:0] trial;
  logic active;
  logic stab_end;
  logic conv_end;
  logic conv_start;
  irq_bits_t irq_status_r;
  irq_bits_t irq_mask_r;
  ctrl_t ctrl_view;
  logic [31:0] read_mux;
  logic [31:0] readdata_r;

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then the access takes effect
  assign req = read_in | write_in;
  assign waitrequest_out = req & ~ack_r;
  assign accept = req & ack_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  assign wr_ctrl = write_in & accept & byteenable_in[0] &
    (address_in == byte_addr(`IDX_CONTROL));
  assign rd_result = read_in & accept &
    (address_in == byte_addr(`IDX_RESULT));
  assign wr_status = write_in & accept & byteenable_in[0] &
    (address_in == byte_addr(`IDX_IRQ_STATUS));
  assign wr_mask = write_in & accept & byteenable_in[0] &
    (address_in == byte_addr(`IDX_IRQ_MASK));

  // Reserved bits are not stored, so they read back as zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view.done = done_r;
    ctrl_view.power_on = power_on_r;
    ctrl_view.zero4 = 1'b0;
    ctrl_view.channel_select = channel_r;
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (address_in)
      byte_addr(`IDX_RESULT): read_mux = {24'h00_0000, result_r};
      byte_addr(`IDX_CONTROL): read_mux = {24'h00_0000, ctrl_view};
      byte_addr(`IDX_IRQ_STATUS): read_mux = {30'h0, irq_status_r};
      byte_addr(`IDX_IRQ_MASK): read_mux = {30'h0, irq_mask_r};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Captured in the wait cycle so the data stand at the accepting edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_r <= 32'h0000_0000;
    end else if (read_in & ~ack_r) begin
      readdata_r <= read_mux;
    end
  end

  assign readdata_out = readdata_r;

  // ==========================================================
  // Control register
  assign power_on_nxt =
    wr_ctrl ? writedata_in[`CTRL_BIT_POWER] : power_on_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_on_r <= 1'b0;
      channel_r <= 3'h0;
    end else if (wr_ctrl) begin
      power_on_r <= power_on_nxt;
      channel_r <= writedata_in[`CTRL_CHAN_MSB:0];
    end
  end

  // Light sleep has no say here, so conversion runs on through it
  assign active = power_on_nxt & ~deep_stop_in;

  // ==========================================================
  // Sequencer
  assign stab_end = (state_r == ST_STAB) &
    (stab_cnt_r == STAB_LAST) & active;
  assign conv_end = (state_r == ST_CONVERT) &
    (cnt_r == CONV_LAST) & ~wr_ctrl & active;
  assign conv_start = (state_r == ST_SAMPLE) & (cnt_r == 6'h00);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_OFF;
    end else if (!active) begin
      state_r <= ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: state_r <= ST_STAB;
        ST_STAB: if (stab_end) begin
          state_r <= ST_SAMPLE;
        end
        ST_SAMPLE: if (!wr_ctrl && cnt_r == SAMPLE_LAST) begin
          state_r <= ST_CONVERT;
        end
        ST_CONVERT: if (wr_ctrl || cnt_r == CONV_LAST) begin
          state_r <= ST_SAMPLE;
        end
      endcase
    end
  end

  // Settling is not restarted by control writes, only by power or wake
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stab_cnt_r <= '0;
    end else if (state_r == ST_STAB && !stab_end) begin
      stab_cnt_r <= STAB_W'(stab_cnt_r + 1'b1);
    end else begin
      stab_cnt_r <= '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 6'h00;
    end else if (wr_ctrl || state_r == ST_OFF || state_r == ST_STAB ||
                 cnt_r == CONV_LAST) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // ==========================================================
  // Sample and successive approximation
  assign trial = sar_r | mask_r;

  // The level is frozen at the end of sampling; later input moves
  // cannot disturb the compare steps
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_r <= '0;
      span_r <= '0;
    end else if (state_r == ST_SAMPLE && cnt_r == SAMPLE_LAST) begin
      hold_r <= above(analog_input_in[channel_r], ref_low_in);
      span_r <= above(ref_high_in, ref_low_in);
    end
  end

  // One bit per cycle, MSB first; a clamped level saturates on its own
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sar_r <= 8'h00;
      mask_r <= 8'h00;
    end else if (state_r == ST_SAMPLE) begin
      sar_r <= 8'h00;
      mask_r <= 8'h80;
    end else if (state_r == ST_CONVERT && mask_r != 8'h00) begin
      if (mul(8'hFF, hold_r) >= mul(trial, span_r)) begin
        sar_r <= trial;
      end
      mask_r <= {1'b0, mask_r[7:1]};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_r <= `RESULT_RESET;
    end else if (conv_end) begin
      result_r <= sar_r;
    end
  end

  // A completion in the cycle of a result read wins over the clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_r <= 1'b0;
    end else if (conv_end) begin
      done_r <= 1'b1;
    end else if (wr_ctrl || rd_result) begin
      done_r <= 1'b0;
    end else if (state_r == ST_OFF || state_r == ST_STAB) begin
      done_r <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status and mask; both masked off at reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r.done <= conv_end |
        (irq_status_r.done & ~(wr_status & writedata_in[0]));
      irq_status_r.ready <= stab_end |
        (irq_status_r.ready & ~(wr_status & writedata_in[1]));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= '0;
    end else if (wr_mask) begin
      irq_mask_r <= writedata_in[1:0];
    end
  end

  assign irq_out = |(irq_status_r & irq_mask_r);

  // ==========================================================
  // Analog-side controls
  assign mux_select_out = channel_r;
  assign converter_enable_out = (state_r != ST_OFF);
  assign sampling_out = (state_r == ST_SAMPLE);

  // ==========================================================
  // Checks
  a_full_scale_sat: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (conv_end && hold_r >= span_r) |=> (result_r == `FULL_SCALE))
    else $error("level at top reference did not give full scale");

  a_floor_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (conv_end && hold_r == '0 && span_r != '0) |=> (result_r == 8'h00))
    else $error("level at bottom reference did not give zero");

  a_conv_length: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    conv_end |-> $past(conv_start, 63))
    else $error("conversion did not last 64 cycles");

  a_sample_length: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ($fell(sampling_out) && state_r == ST_CONVERT) |->
      $past(conv_start, 32))
    else $error("sampling phase was not 32 cycles");

  a_linear_code: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    conv_end |=> (mul(result_r, span_r) <= mul(8'hFF, hold_r)) &&
      (result_r == `FULL_SCALE ||
       mul(8'(result_r + 8'h01), span_r) > mul(8'hFF, hold_r)))
    else $error("result code is not the linear floor");

  a_channel_pick: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl |=> (mux_select_out == $past(writedata_in[2:0])))
    else $error("mux does not follow the channel field");

  a_settle_exit: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    stab_end |=> (state_r == ST_SAMPLE && cnt_r == 6'h00) ##1
      sampling_out)
    else $error("conversion did not start after settling");

  a_settle_count: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_r == ST_STAB && $past(state_r) == ST_STAB) |->
      (stab_cnt_r == STAB_W'($past(stab_cnt_r) + 1'b1)))
    else $error("settle counter skipped");

  a_done_on_end: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    conv_end |=> done_r && (result_r == $past(sar_r)))
    else $error("conversion end did not load result and flag");

  a_write_aborts: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_ctrl |=> !done_r && cnt_r == 6'h00)
    else $error("control write did not abort and clear");

  a_read_clears: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (rd_result && !conv_end) |=> !done_r)
    else $error("result read did not clear the flag");

  a_power_off: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!power_on_r && $past(!power_on_r)) |-> !converter_enable_out)
    else $error("converter runs with power bit clear");

  a_deep_stop: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    deep_stop_in |=> (state_r == ST_OFF))
    else $error("deep stop left the converter running");

  a_bit4_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (read_in && accept && address_in == byte_addr(`IDX_CONTROL)) |->
      (readdata_out[4] == 1'b0 && readdata_out[31:8] == 24'h00_0000))
    else $error("control bit 4 read back as one");

  a_result_held: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !$past(conv_end) |-> (result_r == $past(result_r)))
    else $error("result changed without a conversion end");

  a_settle_quiet: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_r == ST_STAB) |-> !done_r && !$past(conv_end))
    else $error("flag or result moved while settling");

endmodule // adc_sequencer_8bit

`default_nettype wire

/* File: design/adc_seq_consts.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  8-bit converter sequencer. Assumes a 100 MHz core clock.
*/
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_RESULT 8'h70
`define IDX_CONTROL 8'h71
`define IDX_IRQ_STATUS 8'h72
`define IDX_IRQ_MASK 8'h73

// ==========================================================
// Control register fields and reset values
`define CTRL_BIT_DONE 7
`define CTRL_BIT_POWER 5
`define CTRL_CHAN_MSB 2
`define CTRL_RESET 8'h00
`define RESULT_RESET 8'h00
`define FULL_SCALE 8'hFF

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define CONV_CYCLES 64
`define SAMPLE_HALF_CYCLES 63
`define STAB_TIME_NS 30000

`endif

/* File: design/adc_seq_pkg.sv */
/*
  Types shared by the converter sequencer and its bench.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_STAB = 2'b01,
    ST_SAMPLE = 2'b11,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic done;
    logic rsv6;
    logic power_on;
    logic zero4;
    logic rsv3;
    logic [2:0] channel_select;
  } ctrl_t;

  typedef struct packed {
    logic ready;
    logic done;
  } irq_bits_t;

endpackage

`default_nettype wire

/* File: sim/analog_source.sv */
/*
  Far-side model: the eight analog input levels and both references.
  Assumes the bench loads one level per clk_in edge through load_in.
*/
`timescale 1ns/1ps
`default_nettype none

module analog_source #(
  parameter int LEVEL_W = 12,
  parameter logic [LEVEL_W-1:0] REF_LO = 12'h100,
  parameter logic [LEVEL_W-1:0] REF_HI = 12'hF00
) (
  input wire logic clk_in,
  input wire logic load_in,
  input wire logic [2:0] chan_in,
  input wire logic [LEVEL_W-1:0] level_in,
  output logic [7:0][LEVEL_W-1:0] level_out,
  output logic [LEVEL_W-1:0] ref_high_out,
  output logic [LEVEL_W-1:0] ref_low_out
);
  // ==========================================================
  // Pins act as plain inputs: a level holds until reloaded
  initial level_out = '0;
  always @(posedge clk_in) begin
    if (load_in) begin
      level_out[chan_in] <= level_in;
    end
  end
  assign ref_high_out = REF_HI;
  assign ref_low_out = REF_LO;
endmodule // analog_source

`default_nettype wire

/* File: sim/adc_sequencer_8bit_bench.sv */
/*
  Self-checking bench for the converter sequencer: bus reads queue
  their expected data, a monitor compares at each read acceptance whose mask is nonzero.
  Assumes the analog_source model and a shortened settle count.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer_8bit_bench import adc_seq_pkg::*;;
  localparam int STAB = 20;
  localparam int LO = 256;
  localparam int HI = 3840;
  localparam logic [9:0] RES = 10'h1C0;
  localparam logic [9:0] CTL = 10'h1C4;
  localparam logic [9:0] STS = 10'h1C8;
  localparam logic [9:0] MSK = 10'h1CC;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] address_in = '0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = '0;
  logic deep_stop_in = 1'b0;
  logic load = 1'b0;
  logic [2:0] chan = '0;
  logic [11:0] level = '0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic [7:0][11:0] analog;
  logic [11:0] ref_hi;
  logic [11:0] ref_lo;
  logic [2:0] mux_select_out;
  logic converter_enable_out;
  logic sampling_out;
  logic irq_out;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] q;
  ctrl_t ctl;
  int lv[8];
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int run = 0;
  int per = 0;
  int last_run = 0;
  int last_per = 0;

  always #5 clk_in = ~clk_in;

  adc_sequencer_8bit #(.LEVEL_W(12), .STAB_CYCLES(STAB)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(4'hF), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .analog_input_in(analog),
    .ref_high_in(ref_hi), .ref_low_in(ref_lo),
    .deep_stop_in(deep_stop_in), .mux_select_out(mux_select_out),
    .converter_enable_out(converter_enable_out),
    .sampling_out(sampling_out), .irq_out(irq_out)
  );

  analog_source #(.LEVEL_W(12)) far_side (
    .clk_in(clk_in), .load_in(load), .chan_in(chan), .level_in(level),
    .level_out(analog), .ref_high_out(ref_hi), .ref_low_out(ref_lo)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] code_of(input int v);
    if (v <= LO) return 32'h0000_0000;
    if (v >= HI) return 32'h0000_00FF;
    return 32'((255 * (v - LO)) / (HI - LO));
  endfunction

  // Compared at the accepting edge, where the read data stand
  always @(posedge clk_in) begin
    if (read_in && waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      if (msk_q[0] != 0) check(readdata_out & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // Sample-phase length and start-to-start period, plus the timeout
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (sampling_out === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (sampling_out === 1'b1 && run == 0) begin
      last_per <= per;
      per <= 1;
    end else begin
      per <= per + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // ==========================================================
  // Bus master: for a read, d is the expected data under mask m
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= ~wr;
    if (!wr) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    q = '0;
    while (q[7] !== 1'b1 && n < 200) begin
      bus(1'b0, CTL, '0, '0);
      n++;
    end
    check({31'h0, q[7]}, 32'h0000_0001);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h531d3b28));
    for (int i = 0; i < 8; i++) lv[i] = LO + 1 + ($urandom % (HI - LO - 1));
    lv[0] = LO - 5;
    lv[3] = HI;
    lv[4] = LO;
    lv[7] = HI + 64;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      load <= 1'b1;
      chan <= 3'(i);
      level <= 12'(lv[i]);
    end
    @(posedge clk_in);
    load <= 1'b0;
    bus(1'b0, RES, 32'h0000_0000, '1);
    bus(1'b0, CTL, 32'h0000_0000, '1);
    bus(1'b1, RES, 32'h0000_00A5, '0);
    bus(1'b0, RES, 32'h0000_0000, '1);
    bus(1'b0, 10'h3F0, 32'h0000_0000, '1);
    bus(1'b1, CTL, 32'h0000_0000, '0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      ctl = '0;
      ctl.power_on = 1'b1;
      ctl.zero4 = 1'b1;
      ctl.channel_select = 3'(i);
      bus(1'b1, CTL, {24'h0, ctl}, '0);
      bus(1'b0, CTL, 32'h0000_0020 | i, 32'h0000_007F);
      if (i == 0) begin
        @(negedge clk_in);
        check({converter_enable_out, sampling_out}, 32'h2);
      end
      wait_done();
      check({29'h0, mux_select_out}, i);
      bus(1'b0, RES, code_of(lv[i]), '1);
      bus(1'b0, CTL, 32'h0000_0000, 32'h0000_0080);
    end
    $display("test channel sweep done");
    wait_done();
    bus(1'b1, CTL, 32'h0000_0027, '0);
    bus(1'b0, CTL, 32'h0000_0027, '1);
    @(negedge clk_in);
    check({31'h0, sampling_out}, 32'h1);
    repeat (200) @(posedge clk_in);
    check(last_run, 32);
    check(last_per, 64);
    $display("test restart and timing done");
    @(posedge clk_in);
    deep_stop_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    deep_stop_in <= 1'b0;
    @(negedge clk_in);
    check({31'h0, converter_enable_out}, 32'h0);
    repeat (4) @(negedge clk_in);
    check({converter_enable_out, sampling_out}, 32'h2);
    bus(1'b0, RES, code_of(lv[7]), '1);
    bus(1'b0, CTL, 32'h0000_0027, '1);
    wait_done();
    $display("test deep stop done");
    bus(1'b1, MSK, 32'h0000_0001, '0);
    for (int n = 0; n < 200 && irq_out !== 1'b1; n++) @(negedge clk_in);
    check({31'h0, irq_out}, 32'h1);
    bus(1'b0, STS, 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, MSK, 32'h0000_0000, '0);
    @(negedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    bus(1'b1, CTL, 32'h0000_0007, '0);
    bus(1'b1, STS, 32'h0000_0003, '0);
    bus(1'b0, STS, 32'h0000_0000, '1);
    bus(1'b1, MSK, 32'h0000_0003, '0);
    repeat (100) @(negedge clk_in);
    check({irq_out, converter_enable_out, sampling_out}, 32'h0);
    $display("test interrupt and power off done");
    conclude();
  end
endmodule // adc_sequencer_8bit_bench

`default_nettype wire
